// ### ced_pkg.sv
// Package for the comparator event logic: register map, fields, modes
package ced_pkg;
  // ==========================================================================
  // Register word indices and byte addresses
  localparam logic [11:0] CED_IDX_COMP_A = 12'h097;
  localparam logic [11:0] CED_IDX_COMP_B = 12'h09f;
  localparam logic [11:0] CED_ADDR_COMP_A = {CED_IDX_COMP_A[9:0], 2'h0};
  localparam logic [11:0] CED_ADDR_COMP_B = {CED_IDX_COMP_B[9:0], 2'h0};
  localparam logic [11:0] CED_ADDR_SAMPLE = 12'h300;
  localparam logic [11:0] CED_ADDR_IE = 12'h304;
  localparam logic [11:0] CED_ADDR_IRQ_STAT = 12'h308;
  localparam logic [11:0] CED_ADDR_IRQ_MASK = 12'h30c;
  localparam logic [11:0] CED_ADDR_OUT = 12'h310;
  // ==========================================================================
  // Field positions
  localparam int CED_POS_SEL = 6;
  localparam int CED_POS_CONNECT = 5;
  localparam int CED_POS_FLAG = 4;
  localparam int CED_POS_ON = 3;
  localparam int CED_POS_MODE = 0;
  localparam int CED_POS_IE_COMP = 6;
  localparam int CED_POS_SCLK_B = 2;
  localparam int CED_POS_SCLK_A = 0;
  // ==========================================================================
  // Reset values
  localparam logic [7:0] CED_RST_COMP_A = 8'h00;
  localparam logic [7:0] CED_RST_COMP_B = 8'hc0;
  localparam logic [7:0] CED_RST_IE = 8'h00;
  localparam logic [3:0] CED_RST_SAMPLE = 4'h0;
  // ==========================================================================
  // Timing counts
  localparam logic [1:0] CED_DEB_OVF = 2'h2;
  localparam logic [2:0] CED_HOLD_SAMPLES = 3'h4;
  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    CED_LOW = 3'h0, CED_RISE = 3'h1, CED_FTOG = 3'h2, CED_FRISE = 3'h3,
    CED_FALL = 3'h4, CED_TOG = 3'h5, CED_FFALL = 3'h6, CED_HIGH = 3'h7
  } ced_mode_e;
  typedef enum logic [1:0] {
    CED_SRC_SYS = 2'h0, CED_SRC_T0 = 2'h1, CED_SRC_T1 = 2'h2, CED_SRC_T2 = 2'h3
  } ced_src_e;
  typedef enum logic [1:0] {CED_IDLE = 2'h0, CED_WAIT = 2'h1} ced_state_e;
  typedef struct packed {
    logic [1:0] sel;
    logic connect;
    logic flag;
    logic on;
    ced_mode_e mode;
  } ced_ctrl_s;
endpackage

// ### ced_top.sv
// Comparator event logic for two comparators with APB register access
`timescale 1ns/1ps
// What this block does
// - Sample comparators every clock by default
// - Filtered edge modes, with sample select zero, time sampling by timer1
// - After transition wait two timer1 overflows, resample
// - Matching resample sets flag, else discard
// - Filtered event flagged one to two periods later
// - Timer-clocked edges need four stable samples
// - Connect bit routes selected pins to comparator
// - Hardware sets flag on mode match; software clears
// - Interrupt gated by enable register bit six
// - Disable forces output low, blocks flag
// - Either enable holds analog pins input-only
// - Mode field decoding of eight conditions
// - B resets to c0, A to zero
// - Output high when positive exceeds negative
// - Optional sampling on timer 0/1/2 overflow
// - Both comparators share one interrupt
module ced_top import ced_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog front end
  input wire logic [1:0] comp_raw,
  input wire logic [2:0] timer_ovf,
  output logic [1:0] comp_out,
  output logic [3:0] comp_a_pos_select_onehot,
  output logic [3:0] comp_b_pos_select_onehot,
  output logic [1:0] comp_input_connect,
  output logic analog_pins_input_only,
  // Interrupts
  output logic comp_irq,
  output logic irq
);
  // ==========================================================================
  // Registers
  ced_ctrl_s ctrl_reg [2];
  logic [3:0] sample_clock_select_reg;
  logic [7:0] interrupt_enable_reg;
  logic [1:0] irq_stat_reg;
  logic [1:0] irq_mask_reg;
  logic [1:0] smp_reg;
  logic [1:0] prev_reg;
  logic [1:0] cand_reg [2];
  logic [2:0] hold_reg [2];
  logic [1:0] ovf_cnt_reg [2];
  logic [1:0] exp_reg;
  ced_state_e st_reg [2];
  logic [1:0] hit;
  logic wr;
  logic rd;

  function automatic logic [3:0] onehot4(input logic [1:0] s);
    onehot4 = 4'h1 << s;
  endfunction

  function automatic logic tick(input logic [1:0] src, input logic [2:0] ovf);
    case (src)
      CED_SRC_SYS: tick = 1'b1;
      CED_SRC_T0: tick = ovf[0];
      CED_SRC_T1: tick = ovf[1];
      default: tick = ovf[2];
    endcase
  endfunction

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;

  // ==========================================================================
  // APB answer, zero wait
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          CED_ADDR_COMP_A: prdata <= {24'h0, ctrl_reg[0]};
          CED_ADDR_COMP_B: prdata <= {24'h0, ctrl_reg[1]};
          CED_ADDR_SAMPLE: prdata <= {28'h0, sample_clock_select_reg};
          CED_ADDR_IE: prdata <= {24'h0, interrupt_enable_reg};
          CED_ADDR_IRQ_STAT: prdata <= {30'h0, irq_stat_reg};
          CED_ADDR_IRQ_MASK: prdata <= {30'h0, irq_mask_reg};
          CED_ADDR_OUT: prdata <= {30'h0, comp_out};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // ==========================================================================
  // Control registers and event flags
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg[0] <= CED_RST_COMP_A;
      ctrl_reg[1] <= CED_RST_COMP_B;
      sample_clock_select_reg <= CED_RST_SAMPLE;
      interrupt_enable_reg <= CED_RST_IE;
      irq_mask_reg <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wr && paddr == (i == 0 ? CED_ADDR_COMP_A : CED_ADDR_COMP_B)) begin
          ctrl_reg[i] <= pwdata[7:0];
        end
        if (hit[i]) begin
          ctrl_reg[i].flag <= 1'b1;
        end
      end
      if (wr && paddr == CED_ADDR_SAMPLE) sample_clock_select_reg <= pwdata[3:0];
      if (wr && paddr == CED_ADDR_IE) interrupt_enable_reg <= pwdata[7:0];
      if (wr && paddr == CED_ADDR_IRQ_MASK) irq_mask_reg <= pwdata[1:0];
    end
  end

  // ==========================================================================
  // Sampling and event detection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      smp_reg <= 2'h0;
      prev_reg <= 2'h0;
      exp_reg <= 2'h0;
      for (int i = 0; i < 2; i++) begin
        cand_reg[i] <= 2'h0;
        hold_reg[i] <= 3'h0;
        ovf_cnt_reg[i] <= 2'h0;
        st_reg[i] <= CED_IDLE;
      end
      hit <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        logic [1:0] src;
        logic t;
        logic v;
        logic rise;
        logic fall;
        logic filt;
        src = sample_clock_select_reg[2*i +: 2];
        t = 1'b0;
        v = 1'b0;
        rise = 1'b0;
        fall = 1'b0;
        filt = 1'b0;
        hit[i] <= 1'b0;
        // Comparator output: high when plus exceeds minus, low when disabled
        smp_reg[i] <= ctrl_reg[i].on & comp_raw[i];
        filt = ctrl_reg[i].mode inside {CED_FTOG, CED_FRISE, CED_FFALL};
        // Filtered modes use timer1 when select is zero
        if (filt && src == CED_SRC_SYS) t = timer_ovf[1];
        else t = tick(src, timer_ovf);
        v = smp_reg[i];
        if (src != CED_SRC_SYS) begin
          // Edge accepted only after four stable samples
          if (t) begin
            if (v == prev_reg[i]) hold_reg[i] <= 3'h0;
            else if (hold_reg[i] + 3'h1 >= CED_HOLD_SAMPLES) begin
              prev_reg[i] <= v;
              hold_reg[i] <= 3'h0;
              rise = v;
              fall = !v;
            end else hold_reg[i] <= hold_reg[i] + 3'h1;
          end
        end else if (t || filt) begin
          prev_reg[i] <= v;
          rise = v && !prev_reg[i];
          fall = !v && prev_reg[i];
        end
        if (!ctrl_reg[i].on) begin
          st_reg[i] <= CED_IDLE;
        end else if (filt && src == CED_SRC_SYS) begin
          // Debounce: wait two timer1 overflows then resample
          case (st_reg[i])
            CED_IDLE: begin
              if ((rise && ctrl_reg[i].mode != CED_FFALL) || (fall && ctrl_reg[i].mode != CED_FRISE)) begin
                st_reg[i] <= CED_WAIT;
                exp_reg[i] <= rise;
                ovf_cnt_reg[i] <= 2'h0;
              end
            end
            CED_WAIT: begin
              if (timer_ovf[1]) begin
                if (ovf_cnt_reg[i] + 2'h1 >= CED_DEB_OVF) begin
                  st_reg[i] <= CED_IDLE;
                  hit[i] <= (v == exp_reg[i]);
                end else ovf_cnt_reg[i] <= ovf_cnt_reg[i] + 2'h1;
              end
            end
            default: st_reg[i] <= CED_IDLE;
          endcase
        end else if (t || src != CED_SRC_SYS) begin
          case (ctrl_reg[i].mode)
            CED_LOW: hit[i] <= t && !v;
            CED_HIGH: hit[i] <= t && v;
            CED_RISE: hit[i] <= rise;
            CED_FALL: hit[i] <= fall;
            CED_TOG: hit[i] <= rise || fall;
            default: hit[i] <= 1'b0;
          endcase
        end
      end
    end
  end

  // ==========================================================================
  // Interrupt status, read clears, set wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_stat_reg <= 2'h0;
    end else if (rd && paddr == CED_ADDR_IRQ_STAT) begin
      // Clear only what the read returned; a new hit still wins
      irq_stat_reg <= (irq_stat_reg & ~prdata[1:0]) | hit;
    end else begin
      irq_stat_reg <= irq_stat_reg | hit;
    end
  end

  // ==========================================================================
  // Pin controls and interrupt outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      comp_out <= 2'h0;
      comp_a_pos_select_onehot <= 4'h0;
      comp_b_pos_select_onehot <= 4'h0;
      comp_input_connect <= 2'h0;
      analog_pins_input_only <= 1'b0;
      comp_irq <= 1'b0;
      irq <= 1'b0;
    end else begin
      comp_out <= smp_reg;
      comp_a_pos_select_onehot <= ctrl_reg[0].connect ? onehot4(ctrl_reg[0].sel) : 4'h0;
      comp_b_pos_select_onehot <= ctrl_reg[1].connect ? onehot4(ctrl_reg[1].sel) : 4'h0;
      comp_input_connect <= {ctrl_reg[1].connect, ctrl_reg[0].connect};
      analog_pins_input_only <= ctrl_reg[0].on || ctrl_reg[1].on;
      comp_irq <= interrupt_enable_reg[CED_POS_IE_COMP] && (ctrl_reg[0].flag || ctrl_reg[1].flag);
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ==========================================================================
  // Assertions
  a_flag_sticks: assert property (@(posedge clk) disable iff (rst)
    hit[0] |=> ctrl_reg[0].flag) else $error("flag A not set after hit");
  a_off_low: assert property (@(posedge clk) disable iff (rst)
    !ctrl_reg[0].on |-> ##2 !comp_out[0]) else $error("disabled output not low");
  a_pins_io: assert property (@(posedge clk) disable iff (rst)
    (ctrl_reg[0].on || ctrl_reg[1].on) |=> analog_pins_input_only) else $error("pins not input only");
  a_irq_gate: assert property (@(posedge clk) disable iff (rst)
    !interrupt_enable_reg[CED_POS_IE_COMP] |=> !comp_irq) else $error("irq not gated");
  a_connect_off: assert property (@(posedge clk) disable iff (rst)
    !ctrl_reg[0].connect |=> comp_a_pos_select_onehot == 4'h0) else $error("mux not open");
  a_no_hit_off: assert property (@(posedge clk) disable iff (rst)
    !ctrl_reg[0].on |=> !hit[0]) else $error("hit while off");
  a_stat_set: assert property (@(posedge clk) disable iff (rst)
    hit[1] |=> irq_stat_reg[1]) else $error("status B not set");
  a_deb_wait: assert property (@(posedge clk) disable iff (rst)
    st_reg[0] == CED_IDLE ##1 st_reg[0] == CED_WAIT |-> !hit[0]) else $error("early debounce hit");

  a_flag_b_sticks: assert property (@(posedge clk) disable iff (rst)
    hit[1] |=> ctrl_reg[1].flag) else $error("flag B not set after hit");
  a_off_low_b: assert property (@(posedge clk) disable iff (rst)
    !ctrl_reg[1].on |-> ##2 !comp_out[1]) else $error("disabled output B not low");
  a_b_off_quiet: assert property (@(posedge clk) disable iff (rst)
    !ctrl_reg[1].on |=> !hit[1]) else $error("hit B while off");
  a_b_mux_open: assert property (@(posedge clk) disable iff (rst)
    !ctrl_reg[1].connect |=> comp_b_pos_select_onehot == 4'h0) else $error("mux B not open");
  a_mux_routes: assert property (@(posedge clk) disable iff (rst)
    ctrl_reg[0].connect |=> comp_a_pos_select_onehot == onehot4($past(ctrl_reg[0].sel))) else $error("mux A wrong pin");
  a_pins_free: assert property (@(posedge clk) disable iff (rst)
    !(ctrl_reg[0].on || ctrl_reg[1].on) |=> !analog_pins_input_only) else $error("pins held input only");

  a_irq_raise: assert property (@(posedge clk) disable iff (rst)
    interrupt_enable_reg[CED_POS_IE_COMP] && (ctrl_reg[0].flag || ctrl_reg[1].flag) |=> comp_irq)
    else $error("comparator irq not raised");
  a_status_a_set: assert property (@(posedge clk) disable iff (rst)
    hit[0] |=> irq_stat_reg[0]) else $error("status A not set");
  a_irq_level: assert property (@(posedge clk) disable iff (rst)
    |(irq_stat_reg & irq_mask_reg) |=> irq) else $error("irq not raised");
  a_irq_clear: assert property (@(posedge clk) disable iff (rst)
    !(|(irq_stat_reg & irq_mask_reg)) |=> !irq) else $error("irq without cause");

  a_hold_cap: assert property (@(posedge clk) disable iff (rst)
    hold_reg[0] < CED_HOLD_SAMPLES) else $error("hold count A overrun");
  a_b_hold_cap: assert property (@(posedge clk) disable iff (rst)
    hold_reg[1] < CED_HOLD_SAMPLES) else $error("hold count B overrun");
endmodule // ced_top

// ### ced_far_side.sv
// Far-side model: comparator decisions and free-running timer overflows
`timescale 1ns/1ps
module ced_far_side #(parameter int P0 = 6, parameter int P1 = 20, parameter int P2 = 9) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Analog levels
  input wire logic [7:0] pos_a,
  input wire logic [7:0] pos_b,
  input wire logic [7:0] neg,
  // Device side
  output logic [1:0] comp_raw,
  output logic [2:0] timer_ovf
);
  localparam int per[3] = '{P0, P1, P2};
  int cnt[3];
  // ==========================================================================
  // Comparators and timers
  assign comp_raw = {pos_b > neg, pos_a > neg};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= '{0, 0, 0};
      timer_ovf <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        cnt[i] <= (cnt[i] == per[i] - 1) ? 0 : cnt[i] + 1;
        timer_ovf[i] <= (cnt[i] == per[i] - 1);
      end
    end
  end
endmodule // ced_far_side

// ### test_comparator_event_debouncer.sv
// Testbench for the comparator event logic
`timescale 1ns/1ps
module test_comparator_event_debouncer import ced_pkg::*;;
  logic clk = 0;
  logic rst = 1;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata, q;
  logic pready, pslverr, err, comp_irq, irq, input_only;
  logic [1:0] comp_out, connect, comp_raw;
  logic [2:0] timer_ovf;
  logic [3:0] sel_a, sel_b;
  logic [7:0] pos_a = 8'h32;
  logic [7:0] pos_b = 8'h32;
  logic [2:0] md[5] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h7};
  logic [1:0] ex[5] = '{2'h3, 2'h1, 2'h0, 2'h1, 2'h1};
  int bad_count = 0;
  int cmp_count = 0;
  int n;
  initial forever #5 clk = ~clk;
  // ==========================================================================
  // Design and far side
  ced_top dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .comp_raw(comp_raw),
    .timer_ovf(timer_ovf), .comp_out(comp_out), .comp_a_pos_select_onehot(sel_a),
    .comp_b_pos_select_onehot(sel_b), .comp_input_connect(connect), .analog_pins_input_only(input_only),
    .comp_irq(comp_irq), .irq(irq));
  ced_far_side far_u (.clk(clk), .rst(rst), .pos_a(pos_a), .pos_b(pos_b), .neg(8'h64),
    .comp_raw(comp_raw), .timer_ovf(timer_ovf));
  // ==========================================================================
  // Tasks
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      bad_count++;
      tally_and_finish();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wirq(input int lim);
    n = 0;
    while (comp_irq !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (n >= lim) begin
      bad_count++;
      tally_and_finish();
    end
  endtask
  task automatic seta(input logic [31:0] v);
    apb(1'b0, CED_ADDR_COMP_A, 0);
    apb(1'b1, CED_ADDR_COMP_A, q & 32'hdf);
    apb(1'b1, CED_ADDR_COMP_A, v & 32'hdf);
    apb(1'b1, CED_ADDR_COMP_A, v);
    tick(2);
  endtask
  function automatic logic [31:0] ctl(logic [1:0] s, logic c, logic o, logic [2:0] m);
    return {24'h0, s, c, 1'b0, o, m};
  endfunction
  // ==========================================================================
  // Tests
  initial begin
    tick(8);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, CED_ADDR_COMP_A, 0);
    chk(q, 32'h0);
    apb(1'b0, CED_ADDR_COMP_B, 0);
    chk(q, 32'hc0);
    apb(1'b0, 12'hffc, 0);
    chk(err, 1'b1);
    chk(input_only, 1'b0);
    $display("test reset done");
    seta(ctl(2'h2, 1'b1, 1'b1, CED_HIGH));
    chk(sel_a, 4'h4);
    chk(connect, 2'h1);
    chk(input_only, 1'b1);
    pos_a <= 8'h96;
    tick(6);
    chk(comp_out, 2'h1);
    chk(comp_irq, 1'b0);
    apb(1'b1, CED_ADDR_IE, 32'h40);
    tick(2);
    chk(comp_irq, 1'b1);
    apb(1'b0, CED_ADDR_COMP_A, 0);
    chk(q, ctl(2'h2, 1'b1, 1'b1, CED_HIGH) | 32'h10);
    $display("test level done");
    for (int i = 0; i < 5; i++) begin
      pos_a <= 8'h32;
      tick(6);
      seta(ctl(2'h0, 1'b1, 1'b1, md[i]));
      tick(6);
      apb(1'b0, CED_ADDR_COMP_A, 0);
      chk(q[4], ex[i][1]);
      pos_a <= 8'h96;
      tick(6);
      apb(1'b0, CED_ADDR_COMP_A, 0);
      chk(q[4], ex[i][0]);
      pos_a <= 8'h32;
      tick(6);
      apb(1'b0, CED_ADDR_COMP_A, 0);
      chk(q[4], 1'b1);
    end
    $display("test modes done");
    pos_a <= 8'h96;
    seta(ctl(2'h0, 1'b1, 1'b0, CED_HIGH));
    tick(6);
    chk(comp_out, 2'h0);
    apb(1'b0, CED_ADDR_COMP_A, 0);
    chk(q, ctl(2'h0, 1'b1, 1'b0, CED_HIGH));
    chk(input_only, 1'b0);
    $display("test disable done");
    pos_a <= 8'h32;
    seta(ctl(2'h0, 1'b1, 1'b1, CED_FRISE));
    pos_a <= 8'h96;
    tick(3);
    pos_a <= 8'h32;
    tick(60);
    chk(comp_irq, 1'b0);
    pos_a <= 8'h96;
    wirq(60);
    chk(n >= 18 && n <= 46, 1'b1);
    seta(ctl(2'h0, 1'b1, 1'b1, CED_FTOG));
    pos_a <= 8'h32;
    wirq(60);
    chk(n >= 18 && n <= 46, 1'b1);
    $display("test filtered done");
    apb(1'b1, CED_ADDR_SAMPLE, 32'h1);
    pos_a <= 8'h32;
    seta(ctl(2'h0, 1'b1, 1'b1, CED_RISE));
    tick(30);
    pos_a <= 8'h96;
    tick(12);
    chk(comp_irq, 1'b0);
    wirq(40);
    chk(n < 40, 1'b1);
    $display("test timer sampling done");
    apb(1'b1, CED_ADDR_SAMPLE, 32'h0);
    seta(ctl(2'h0, 1'b1, 1'b1, CED_RISE));
    apb(1'b0, CED_ADDR_IRQ_STAT, 0);
    apb(1'b1, CED_ADDR_IRQ_MASK, 32'hff);
    pos_a <= 8'h32;
    tick(6);
    chk(irq, 1'b0);
    pos_a <= 8'h96;
    tick(8);
    chk(irq, 1'b1);
    apb(1'b0, CED_ADDR_IRQ_STAT, 0);
    chk(q, 32'h1);
    tick(2);
    chk(irq, 1'b0);
    seta(ctl(2'h0, 1'b1, 1'b0, CED_RISE));
    pos_b <= 8'h96;
    apb(1'b1, CED_ADDR_COMP_B, ctl(2'h0, 1'b0, 1'b1, CED_HIGH));
    apb(1'b1, CED_ADDR_COMP_B, ctl(2'h0, 1'b1, 1'b1, CED_HIGH));
    tick(8);
    chk(comp_irq, 1'b1);
    chk(irq, 1'b1);
    chk(sel_b, 4'h1);
    chk(comp_out, 2'h2);
    apb(1'b0, CED_ADDR_OUT, 0);
    chk(q, 32'h2);
    $display("test interrupt done");
    tally_and_finish();
  end
endmodule // test_comparator_event_debouncer
